//--- rtl/adc_cal_map.svh
`ifndef ADC_CAL_MAP_SVH
`define ADC_CAL_MAP_SVH

// register offsets (byte index on the plain port)
`define REG_CAL_CTRL        8'h00
`define REG_CAL_STATUS      8'h01
`define REG_TRIM_BASE       8'h10
`define REG_TRIM_LAST       8'h21
`define REG_SRC_DLY         8'h9a
`define REG_MUX_DLY         8'h9b

// control register field positions
`define CTRL_SOFT_TRIG      0
`define CTRL_TRIG_SEL       1
`define CTRL_BG_EN          2
`define CTRL_FG_OFS         3
`define CTRL_BG_OFS         4

// reset values
`define CTRL_RESET          8'h00
`define DLY_RESET           8'h00
`define TRIM_FACTORY        8'h80

// core numbering
`define NUM_CORES           6
`define NUM_TRIMS           18
`define CORE_A              3'h0
`define CORE_B              3'h1
`define CORE_SPARE_AB       3'h2
`define CORE_SPARE_CD       3'h3
`define CORE_C              3'h4
`define CORE_D              3'h5

// mid-code output while offline
`define MID_CODE            9'h000

// calibration timing, cycles of the 200 MHz clock
`define CAL_CYCLES          16'h0100
`define OFS_CYCLES          16'h0040
`define BG_CAL_CYCLES       16'h0200

`endif

//--- rtl/adc_cal_pkg.sv
package adc_cal_pkg;
    typedef enum logic [1:0] {
        variant_quad_type_e,
        variant_dual_type_e,
        variant_single_type_e
    } variant_type;

    typedef logic [8:0] sample_type;
endpackage

//--- rtl/adc_core_calibration_control.sv
// The address-and-strobe port was chosen for this implementation.
`include "adc_cal_map.svh"
module adc_core_calibration_control
    import adc_cal_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [7:0]  rdata_o,
    input  wire logic        calibration_trigger_pin_i,
    input  wire variant_type variant_i,
    input  wire sample_type  core_sample_i [`NUM_CORES],
    output sample_type       input_channel_a_o,
    output sample_type       input_channel_b_o,
    output sample_type       input_channel_c_o,
    output sample_type       input_channel_d_o,
    output logic      [5:0]  core_calibrating_o,
    output logic             foreground_cal_complete_o
);
    // =====================================================
    // state and registers
    typedef enum logic [2:0] {
        st_fg_cal, st_fg_ofs, st_idle, st_bg_cal, st_bg_src, st_bg_mux
    } cal_state_type;

    cal_state_type state_q, state_d;
    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  src_dly_q, src_dly_d;
    logic [7:0]  mux_dly_q, mux_dly_d;
    logic [15:0] cnt_q, cnt_d;
    logic        foreground_cal_complete_q, foreground_cal_complete_d;
    logic        trig_prev_q, trig_prev_d;
    logic        rd_trim_q, rd_trim_d;
    logic [7:0]  rdata_q, rdata_d;
    logic [2:0]  cal_core_q, cal_core_d;   // core now offline
    logic [2:0]  slot_q [4];               // core serving each channel
    logic [2:0]  slot_d [4];
    logic [1:0]  rot_q, rot_d;             // channel being replaced
    logic [2:0]  spare_q [2];              // offline core of each pair
    logic [2:0]  spare_d [2];
    sample_type  out_q [4];
    sample_type  out_d [4];
    logic        trig_pin_lvl;
    logic        trig_lvl;
    logic        trig_rise;
    logic        bg_en;

    trim_if trim_bus ();

    cal_trig_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .pin_i     (calibration_trigger_pin_i),
        .level_o   (trig_pin_lvl)
    );

    trim_mem u_trim (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .port_io   (trim_bus.mem)
    );

    // =====================================================
    // helpers
    function automatic logic is_trim(input logic [7:0] a);
        return (a >= `REG_TRIM_BASE) && (a <= `REG_TRIM_LAST);
    endfunction

    // pair of a channel slot: A,B share one spare, C,D the other
    function automatic logic pair_of(input logic [1:0] ch);
        return ch[1];
    endfunction

    // channels taking part in rotation per variant
    function automatic logic [1:0] next_ch(input logic [1:0] ch,
                                           input variant_type v);
        logic [1:0] n;
        n = 2'(ch + 2'h1);
        unique case (v)
            variant_quad_type_e:   next_ch = n;
            variant_dual_type_e:   next_ch = {1'b0, ~ch[0]};
            variant_single_type_e: next_ch = 2'h0;
            default:               next_ch = 2'h0;
        endcase
    endfunction

    // trigger source select, then software or pin level
    assign trig_lvl  = ctrl_q[`CTRL_TRIG_SEL] ? trig_pin_lvl
                       : ctrl_q[`CTRL_SOFT_TRIG];
    assign trig_rise = trig_lvl && !trig_prev_q;
    assign bg_en     = ctrl_q[`CTRL_BG_EN];

    // =====================================================
    // register port: writes, reads, trim access
    always_comb begin
        ctrl_d    = ctrl_q;
        src_dly_d = src_dly_q;
        mux_dly_d = mux_dly_q;
        rd_trim_d = rd_i && is_trim(addr_i);
        rdata_d   = 8'h00;
        trim_bus.we    = wr_i && is_trim(addr_i);
        trim_bus.waddr = 5'(addr_i - `REG_TRIM_BASE);
        trim_bus.wdata = wdata_i;
        trim_bus.raddr = 5'(addr_i - `REG_TRIM_BASE);
        if (wr_i) begin
            unique case (addr_i)
                `REG_CAL_CTRL: ctrl_d    = {3'h0, wdata_i[4:0]};
                `REG_SRC_DLY:  src_dly_d = wdata_i;
                `REG_MUX_DLY:  mux_dly_d = wdata_i;
                default: ;
            endcase
        end
        if (rd_i) begin
            unique case (addr_i)
                `REG_CAL_CTRL:   rdata_d = ctrl_q;
                `REG_CAL_STATUS: rdata_d = {2'h0, cal_core_q,
                                            bg_en, state_q == st_idle
                                            || !(state_q inside
                                            {st_fg_cal, st_fg_ofs}),
                                            foreground_cal_complete_q};
                `REG_SRC_DLY:    rdata_d = src_dly_q;
                `REG_MUX_DLY:    rdata_d = mux_dly_q;
                default:         rdata_d = 8'h00;
            endcase
        end
    end

    // trim reads come from the memory register one cycle later
    assign rdata_o = rd_trim_q ? trim_bus.rdata : rdata_q;

    // =====================================================
    // calibration sequencer
    always_comb begin
        state_d     = state_q;
        cnt_d       = cnt_q;
        foreground_cal_complete_d   = foreground_cal_complete_q;
        trig_prev_d = trig_lvl;
        cal_core_d  = cal_core_q;
        rot_d       = rot_q;
        slot_d      = slot_q;
        spare_d     = spare_q;
        unique case (state_q)
            // all cores offline; linearity, gain, offset run together
            st_fg_cal: begin
                if (cnt_q == `CAL_CYCLES) begin
                    cnt_d   = 16'h0000;
                    state_d = ctrl_q[`CTRL_FG_OFS] ? st_fg_ofs
                                                   : st_idle;
                end else begin
                    cnt_d = 16'(cnt_q + 16'h0001);
                end
            end
            // one offset pass, only inside foreground cal
            st_fg_ofs: begin
                if (cnt_q == `OFS_CYCLES) begin
                    cnt_d   = 16'h0000;
                    state_d = st_idle;
                end else begin
                    cnt_d = 16'(cnt_q + 16'h0001);
                end
            end
            st_idle: begin
                foreground_cal_complete_d = 1'b1;
                if (bg_en && trig_lvl) begin
                    state_d    = st_bg_cal;
                    cnt_d      = 16'h0000;
                    cal_core_d = spare_q[pair_of(rot_q)];
                end
            end
            // a single offline core calibrates
            st_bg_cal: begin
                if (cnt_q == `BG_CAL_CYCLES) begin
                    cnt_d   = 16'h0000;
                    state_d = st_bg_src;
                end else begin
                    cnt_d = 16'(cnt_q + 16'h0001);
                end
            end
            // incoming core settles, then mux moves
            st_bg_src: begin
                if (cnt_q >= {8'h00, src_dly_q}) begin
                    cnt_d   = 16'h0000;
                    state_d = st_bg_mux;
                end else begin
                    cnt_d = 16'(cnt_q + 16'h0001);
                end
            end
            st_bg_mux: begin
                if (cnt_q >= {8'h00, mux_dly_q}) begin
                    // fresh core takes over; replaced core goes offline
                    slot_d[rot_q]           = cal_core_q;
                    spare_d[pair_of(rot_q)] = slot_q[rot_q];
                    rot_d = next_ch(rot_q, variant_i);
                    // freed core stays in its pair; a pair change picks
                    // the other pair's spare so no core is skipped
                    if (pair_of(rot_d) == pair_of(rot_q)) begin
                        cal_core_d = slot_q[rot_q];
                    end else begin
                        cal_core_d = spare_q[pair_of(rot_d)];
                    end
                    cnt_d         = 16'h0000;
                    state_d       = bg_en ? st_bg_cal : st_idle;
                end else begin
                    cnt_d = 16'(cnt_q + 16'h0001);
                end
            end
            default: state_d = st_idle;
        endcase
        // a trigger edge with background off starts foreground unless one is already running
        if (trig_rise && !bg_en &&
            !(state_q inside {st_fg_cal, st_fg_ofs})) begin
            state_d   = st_fg_cal;
            cnt_d     = 16'h0000;
            foreground_cal_complete_d = 1'b0;
            slot_d    = '{`CORE_A, `CORE_B, `CORE_C, `CORE_D};
            spare_d   = '{`CORE_SPARE_AB, `CORE_SPARE_CD};
        end
    end

    // =====================================================
    // output data path: mid-code while offline, else routed core
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            if (state_q inside {st_fg_cal, st_fg_ofs}) begin
                out_d[c] = `MID_CODE;
            end else begin
                out_d[c] = core_sample_i[slot_q[c]];
            end
        end
    end

    // =====================================================
    // registers; reset enters power-up foreground calibration
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q     <= st_fg_cal;
            cnt_q       <= 16'h0000;
            ctrl_q      <= `CTRL_RESET;
            src_dly_q   <= `DLY_RESET;
            mux_dly_q   <= `DLY_RESET;
            foreground_cal_complete_q   <= 1'b0;
            trig_prev_q <= 1'b0;
            rd_trim_q   <= 1'b0;
            rdata_q     <= 8'h00;
            cal_core_q  <= `CORE_SPARE_AB;
            rot_q       <= 2'h0;
            slot_q      <= '{`CORE_A, `CORE_B, `CORE_C, `CORE_D};
            spare_q     <= '{`CORE_SPARE_AB, `CORE_SPARE_CD};
            out_q       <= '{`MID_CODE, `MID_CODE, `MID_CODE, `MID_CODE};
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            ctrl_q      <= ctrl_d;
            src_dly_q   <= src_dly_d;
            mux_dly_q   <= mux_dly_d;
            foreground_cal_complete_q   <= foreground_cal_complete_d;
            trig_prev_q <= trig_prev_d;
            rd_trim_q   <= rd_trim_d;
            rdata_q     <= rdata_d;
            cal_core_q  <= cal_core_d;
            rot_q       <= rot_d;
            slot_q      <= slot_d;
            spare_q     <= spare_d;
            out_q       <= out_d;
        end
    end

    // which core is offline for calibration (one-hot in background, all six bits in foreground cal)
    always_comb begin
        core_calibrating_o = 6'h00;
        if (state_q inside {st_fg_cal, st_fg_ofs}) begin
            core_calibrating_o = 6'h3f;
        end else if (state_q != st_idle) begin
            core_calibrating_o[cal_core_q] = 1'b1;
        end
    end

    assign input_channel_a_o         = out_q[0];
    assign input_channel_b_o         = out_q[1];
    assign input_channel_c_o         = out_q[2];
    assign input_channel_d_o         = out_q[3];
    assign foreground_cal_complete_o = foreground_cal_complete_q;
endmodule

//--- rtl/cal_trig_sync.sv
module cal_trig_sync (
    input  wire logic clk_sys_i,
    input  wire logic resetn_i,
    input  wire logic pin_i,
    output logic      level_o
);
    // =====================================================
    // three-stage pin synchroniser
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic       level_q;
    logic       level_d;

    // level moves only when stages two and three agree
    always_comb begin
        sync_d  = {sync_q[1:0], pin_i};
        level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync_q  <= 3'h0;
            level_q <= 1'b0;
        end else begin
            sync_q  <= sync_d;
            level_q <= level_d;
        end
    end

    assign level_o = level_q;
endmodule

//--- rtl/trim_if.sv
// trim memory access shared between controller and memory
interface trim_if;
    logic       we;
    logic [4:0] waddr;
    logic [7:0] wdata;
    logic [4:0] raddr;
    logic [7:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr,
                  input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr,
                  output rdata);
endinterface

//--- rtl/trim_mem.sv
`include "adc_cal_map.svh"
module trim_mem (
    input  wire logic clk_sys_i,
    input  wire logic resetn_i,
    trim_if.mem       port_io
);
    // =====================================================
    // trim storage
    logic [7:0] mem_q [`NUM_TRIMS];
    logic [7:0] mem_d [`NUM_TRIMS];
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // one write port, registered read port
    always_comb begin
        mem_d = mem_q;
        if (port_io.we && port_io.waddr < 5'(`NUM_TRIMS)) begin
            mem_d[port_io.waddr] = port_io.wdata;
        end
        rdata_d = (port_io.raddr < 5'(`NUM_TRIMS)) ?
                  mem_q[port_io.raddr] : 8'h00;
    end

    // factory values come back at reset
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < `NUM_TRIMS; i++) begin
                mem_q[i] <= `TRIM_FACTORY;
            end
            rdata_q <= 8'h00;
        end else begin
            mem_q   <= mem_d;
            rdata_q <= rdata_d;
        end
    end

    assign port_io.rdata = rdata_q;
endmodule

//--- sim/adc_cal_chk.sv
`include "adc_cal_map.svh"
module adc_cal_chk
    import adc_cal_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [7:0]  rdata_o,
    input  wire variant_type variant_i,
    input  wire sample_type  input_channel_a_o,
    input  wire sample_type  input_channel_b_o,
    input  wire sample_type  input_channel_c_o,
    input  wire sample_type  input_channel_d_o,
    input  wire logic [5:0]  core_calibrating_o,
    input  wire logic        foreground_cal_complete_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================
    // power-up span counter
    logic [9:0] up_cnt_q;
    logic [9:0] up_cnt_d;
    logic       seen_q;
    logic       seen_d;

    // freezes once the first completion is seen, so retriggers do not count
    always_comb begin
        seen_d   = seen_q | foreground_cal_complete_o;
        up_cnt_d = seen_q ? up_cnt_q : up_cnt_q + 10'h001;
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            up_cnt_q <= 10'h000;
            seen_q   <= 1'b0;
        end else begin
            up_cnt_q <= up_cnt_d;
            seen_q   <= seen_d;
        end
    end

    // ========================================
    // properties
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    // registered outputs lag the offline flag, hence three cycles
    AST_MID_CODE: assert property (core_calibrating_o == 6'h3f [*3]
        |-> input_channel_a_o == `MID_CODE && input_channel_b_o == `MID_CODE
            && input_channel_c_o == `MID_CODE
            && input_channel_d_o == `MID_CODE)
        else $error("output not mid-code while offline");
    AST_DONE_AFTER_CAL: assert property ($rose(foreground_cal_complete_o)
        |-> $past(core_calibrating_o, 2) == 6'h3f)
        else $error("complete without foreground cal");
    AST_POWERUP_CAL: assert property (
        $rose(foreground_cal_complete_o) && !seen_q
        |-> up_cnt_q >= 10'd255 && up_cnt_q <= 10'd260)
        else $error("power-up cal length wrong");
    AST_ONE_CORE: assert property (core_calibrating_o != 6'h3f
        |-> $onehot0(core_calibrating_o))
        else $error("several cores calibrating");
    AST_SPARE3_QUAD: assert property (
        core_calibrating_o[3] && core_calibrating_o != 6'h3f
        |-> variant_i == variant_quad_type_e)
        else $error("core 3 used outside quad");
    AST_DUAL_CORES: assert property (
        variant_i == variant_dual_type_e && core_calibrating_o != 6'h3f
        |-> (core_calibrating_o & 6'h38) == 6'h00)
        else $error("dual uses a core beyond 2");
    AST_SINGLE_CORES: assert property (
        variant_i == variant_single_type_e && core_calibrating_o != 6'h3f
        |-> (core_calibrating_o & 6'h3a) == 6'h00)
        else $error("single uses a core other than 0 or 2");
    AST_TRIM_RW: assert property (
        wr_i && addr_i == `REG_TRIM_BASE ##1 rd_i && addr_i == `REG_TRIM_BASE
        |=> rdata_o == $past(wdata_i, 2))
        else $error("trim readback differs");
    AST_DLY_RW: assert property (
        wr_i && addr_i == `REG_SRC_DLY ##1 rd_i && addr_i == `REG_SRC_DLY
        |=> rdata_o == $past(wdata_i, 2))
        else $error("delay readback differs");
endmodule

bind adc_core_calibration_control adc_cal_chk u_chk (
    .clk_sys_i                 (clk_sys_i),
    .resetn_i                  (resetn_i),
    .addr_i                    (addr_i),
    .wdata_i                   (wdata_i),
    .wr_i                      (wr_i),
    .rd_i                      (rd_i),
    .rdata_o                   (rdata_o),
    .variant_i                 (variant_i),
    .input_channel_a_o         (input_channel_a_o),
    .input_channel_b_o         (input_channel_b_o),
    .input_channel_c_o         (input_channel_c_o),
    .input_channel_d_o         (input_channel_d_o),
    .core_calibrating_o        (core_calibrating_o),
    .foreground_cal_complete_o (foreground_cal_complete_o)
);

//--- sim/test_adc_core_calibration_control.sv
`include "adc_cal_map.svh"
module test_adc_core_calibration_control
    import adc_cal_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [7:0]  wdata_i = 8'h00;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [7:0]  rdata_o;
    logic        pin_i = 1'b0;
    variant_type variant_i = variant_quad_type_e;
    sample_type  smp [`NUM_CORES];
    sample_type  cha, chb, chc, chd;
    logic [5:0]  cc;
    logic        done;
    int          miscompares = 0;
    int          checks = 0;
    int          n, d0, d1;

    adc_core_calibration_control u_dut (
        .clk_sys_i                 (clk_sys_i),
        .resetn_i                  (resetn_i),
        .addr_i                    (addr_i),
        .wdata_i                   (wdata_i),
        .wr_i                      (wr_i),
        .rd_i                      (rd_i),
        .rdata_o                   (rdata_o),
        .calibration_trigger_pin_i (pin_i),
        .variant_i                 (variant_i),
        .core_sample_i             (smp),
        .input_channel_a_o         (cha),
        .input_channel_b_o         (chb),
        .input_channel_c_o         (chc),
        .input_channel_d_o         (chd),
        .core_calibrating_o        (cc),
        .foreground_cal_complete_o (done)
    );

    // ========================================
    // clock and helpers
    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
    endtask

    // data is looked at only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i   <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {1'b0, e}, {1'b0, rdata_o});
    endtask

    // write then read back with no gap between the two strobes
    task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i    <= 1'b0;
        rd_i    <= 1'b1;
        @(posedge clk_sys_i);
        rd_i    <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {1'b0, d}, {1'b0, rdata_o});
    endtask

    // bounded wait for the offline flags to become (eq) or leave v
    task automatic wt(input logic [5:0] v, input logic eq, output int k);
        k = 0;
        while (((cc === v) !== eq) && k < 700) begin
            @(posedge clk_sys_i);
            #1;
            k++;
        end
    endtask

    task automatic rst(input variant_type v);
        resetn_i  <= 1'b0;
        variant_i <= v;
        repeat (6) @(posedge clk_sys_i);
        resetn_i  <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        chk("pwrup offline", 9'h03f, {3'h0, cc});
        chk("pwrup mid", `MID_CODE, cha);
        wt(6'h3f, 1'b0, n);
        // complete flag and routed samples trail the state by one edge
        @(posedge clk_sys_i);
        #1;
        chk("pwrup done", 9'h001, {8'h00, done & (n < 700)});
    endtask

    // software trigger with extra control bits; returns offline span
    task automatic fg(input logic [7:0] c, output int k);
        wr(`REG_CAL_CTRL, c);
        wr(`REG_CAL_CTRL, c | 8'h01);
        wt(6'h3f, 1'b1, k);
        chk("sw trig start", 9'h001, {8'h00, k < 20});
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk("fg mid", `MID_CODE, chd);
        wt(6'h3f, 1'b0, k);
        wr(`REG_CAL_CTRL, 8'h00);
    endtask

    // background rotation: channel A never held, each core in mask m seen offline
    task automatic bg(input variant_type v, input logic [5:0] m);
        logic [5:0] seen;
        logic       ok;
        seen = 6'h00;
        ok   = 1'b1;
        rst(v);
        wr(`REG_SRC_DLY, 8'h1f);
        wr(`REG_MUX_DLY, 8'h1e);
        wr(`REG_CAL_CTRL, 8'h04);
        wr(`REG_CAL_CTRL, 8'h05);
        repeat (5000) begin
            @(posedge clk_sys_i);
            #1;
            seen = seen | cc;
            if (cc === 6'h3f || !(cha === smp[0] || cha === smp[1]
                || cha === smp[2]))
                ok = 1'b0;
        end
        chk("bg no hold", 9'h001, {8'h00, ok});
        chk("bg cores", {3'h0, m}, {3'h0, seen});
        $display("background test done, variant %0d", v);
    endtask

    // ========================================
    // main sequence
    initial begin
        for (int i = 0; i < `NUM_CORES; i++)
            smp[i] = 9'h0a1 + 9'(i);
        rst(variant_quad_type_e);
        chk("route a", smp[0], cha);
        chk("route b", smp[1], chb);
        chk("route c", smp[4], chc);
        chk("route d", smp[5], chd);
        $display("power-up test done");
        rd(`REG_SRC_DLY, `DLY_RESET);
        rd(`REG_MUX_DLY, `DLY_RESET);
        rd(`REG_CAL_STATUS, 8'h13); // spare 2 parked, online, complete
        rd(`REG_TRIM_BASE, `TRIM_FACTORY);
        rd(`REG_TRIM_LAST, `TRIM_FACTORY);
        wrrd(`REG_TRIM_BASE, 8'h5a);
        wrrd(`REG_SRC_DLY, 8'h1f);
        rd(8'h50, 8'h00);
        $display("register test done");
        fg(8'h00, d0);
        fg(8'h08, d1);
        chk("ofs extra", 9'h001, {8'h00, (d1 - d0 >= `OFS_CYCLES)
            && (d1 - d0 <= `OFS_CYCLES + 1)});
        wr(`REG_CAL_CTRL, 8'h02);
        wr(`REG_CAL_CTRL, 8'h03);
        wt(6'h3f, 1'b1, n);
        chk("sw ignored", 9'h001, {8'h00, n >= 20});
        @(posedge clk_sys_i);
        pin_i <= 1'b1;
        wt(6'h3f, 1'b1, n);
        chk("pin start", 9'h001, {8'h00, n < 20});
        wt(6'h3f, 1'b0, n);
        @(posedge clk_sys_i);
        pin_i <= 1'b0;
        wr(`REG_CAL_CTRL, 8'h00);
        $display("trigger test done");
        bg(variant_quad_type_e, 6'h3f);
        bg(variant_dual_type_e, 6'h07);
        bg(variant_single_type_e, 6'h05);
        conclude();
    end

    // about 20k cycles expected; twice that means a hang
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
endmodule
